/* design/tcs_pkg.sv */
package tcs_pkg;

  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;   // Trace mode, 32-bit comparator enable
  localparam logic [7:0] OFS_ADDR_VAL = 8'h04;
  localparam logic [7:0] OFS_ADDR_MSK = 8'h08;
  localparam logic [7:0] OFS_DATA1 = 8'h0c;  // 32-bit write when wide comparators on outside base mode
  localparam logic [7:0] OFS_DATA2 = 8'h10;
  localparam logic [7:0] OFS_DMSK = 8'h14;   // Data don't-care mask, upper word
  localparam logic [7:0] OFS_PROBE = 8'h18;  // Logic-probe value [15:0], mask [31:16]
  localparam logic [7:0] OFS_STAT1 = 8'h1c;  // Status value [14:0], mask [30:16]
  localparam logic [7:0] OFS_STAT2 = 8'h20;
  localparam logic [7:0] OFS_COND = 8'h24;   // AND-select of matches
  localparam logic [7:0] OFS_STATUS = 8'h28; // Error sticky, break, matches
  localparam logic [7:0] OFS_TRACE = 8'h2c;  // Read pops one trace word

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_WIDE_BIT = 2;
  localparam logic [1:0] MODE_BASE = 2'h0;
  localparam logic [1:0] MODE_WIDE_DATA = 2'h1;
  localparam logic [1:0] MODE_FULL_ADDR = 2'h2;
  localparam logic [1:0] RST_MODE = 2'h2;
  localparam int COND_ADDR = 0;
  localparam int COND_DATA1 = 1;
  localparam int COND_DATA2 = 2;
  localparam int COND_STAT1 = 3;
  localparam int COND_STAT2 = 4;
  localparam int COND_PROBE = 5;
  localparam int COND_BREAK = 6;             // Status write bit that clears the break
  localparam int STAT_HI_LSB = 7;            // Status bits 14:7 hold address 31:24
  localparam int TRACE_WORDS = 4;            // Words popped per traced cycle

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [15:0] probe;
    logic interrupt_pending;
    logic autovector;
    logic [2:0] interrupt_level_lines;
    logic bus_error_flag;
    logic access_violation;
    logic [2:0] func_code;
    logic user_system_cycle;
    logic read_cycle;
    logic single_octet_size;
    logic op_cycle_start;
    logic sized_transfer_ack_high;
    logic sized_transfer_ack_low;
    logic transfer_size_bit_high;
    logic transfer_size_bit_low;
    logic strobe;
  } tcs_bus_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic [14:0] status;
    logic [15:0] probe;
    logic [4:0] extra;
  } tcs_rec_t;

  localparam int REC_W = $bits(tcs_rec_t);

endpackage : tcs_pkg

/* design/tcs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tcs_fifo #(
  parameter int WIDTH = 76,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("tcs_fifo: depth must be a power of two above one");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];     // Flip-flop storage
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic push;
  logic pop;

  assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data = mem_ff[rd_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : tcs_fifo
`default_nettype wire

/* design/tcs_trace_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module tcs_trace_cmp
  import tcs_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Target bus, asynchronous pins
  input wire tcs_bus_t target_bus,
  // Break action
  output logic break_action
);

  initial
  begin
    if (FIFO_DEPTH != 32)
      $error("tcs_trace_cmp: trace buffer depth must be 32");
  end

  // ****************************************************************
  // Pin synchroniser and cycle strobe
  // ****************************************************************
  tcs_bus_t sync1_ff;   // First stage, read only by second stage
  tcs_bus_t sync2_ff;
  tcs_bus_t bus;        // Sampled cycle
  logic strobe_d_ff;
  logic cyc;            // One pulse per traced target cycle

  // Two stages on every pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= target_bus;
      sync2_ff <= sync1_ff;
    end
  end

  // Hold strobe history for edge detect
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      strobe_d_ff <= 1'b0;
    else
      strobe_d_ff <= sync2_ff.strobe;
  end

  assign bus = sync2_ff;
  assign cyc = sync2_ff.strobe && !strobe_d_ff;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [1:0] mode_ff;          // Trace mode
  logic wide_ff;                // 32-bit comparators enabled
  logic [23:0] addr_val_ff;
  logic [23:0] addr_msk_ff;     // Set bit means don't care
  logic [15:0] data1_ff;        // Upper data word, first comparator
  logic [15:0] data2_ff;
  logic [15:0] dmsk_ff;
  logic [15:0] probe_val_ff;    // Shared low word in wide modes
  logic [15:0] probe_msk_ff;
  logic [14:0] stat1_ff;
  logic [14:0] stat1_msk_ff;
  logic [14:0] stat2_ff;
  logic [14:0] stat2_msk_ff;
  logic [5:0] cond_ff;          // AND-select of matches
  logic err_ff;                 // Sticky refused-command flag
  logic wr_en;
  logic rd_en;
  logic probe_locked;           // Probe comparator owned by data path
  logic addr_in_stat;           // Status high bits hold address
  logic bad_cond;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // Wide comparators only reshape things outside base mode (modes 1 to 3)
  assign probe_locked = wide_ff && (mode_ff != MODE_BASE);
  assign addr_in_stat = wide_ff && (mode_ff == MODE_FULL_ADDR);
  assign bad_cond = probe_locked && pwdata[COND_PROBE];

  // Masked compare, reused by every comparator
  function automatic logic hit16(input logic [15:0] v, input logic [15:0] r,
                                 input logic [15:0] m);
    hit16 = ((v ^ r) & ~m) == 16'h0000;
  endfunction : hit16

  // Comparator value registers; also the mode and enable bits
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_ff <= RST_MODE;
      wide_ff <= 1'b0;
      addr_val_ff <= '0;
      addr_msk_ff <= '1;
      data1_ff <= '0;
      data2_ff <= '0;
      dmsk_ff <= '1;
      probe_val_ff <= '0;
      probe_msk_ff <= '1;
      stat1_ff <= '0;
      stat1_msk_ff <= '1;
      stat2_ff <= '0;
      stat2_msk_ff <= '1;
      cond_ff <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        OFS_CTRL:
        begin
          mode_ff <= pwdata[1:0];
          wide_ff <= pwdata[CTRL_WIDE_BIT];
        end
        OFS_ADDR_VAL:
        begin
          addr_val_ff <= pwdata[23:0];
          // High byte lands in status bits 14:7 in wide full-address use
          if (addr_in_stat)
          begin
            stat1_ff[14:STAT_HI_LSB] <= pwdata[31:24];
            stat1_msk_ff[14:STAT_HI_LSB] <= 8'h00;
          end
        end
        OFS_ADDR_MSK:
          addr_msk_ff <= pwdata[23:0];
        OFS_DATA1, OFS_DATA2:
        begin
          if (paddr == OFS_DATA1)
            data1_ff <= probe_locked ? pwdata[31:16] : pwdata[15:0];
          else
            data2_ff <= probe_locked ? pwdata[31:16] : pwdata[15:0];
          // Lower half goes to the shared probe comparator
          if (probe_locked)
          begin
            probe_val_ff <= pwdata[15:0];
            probe_msk_ff <= dmsk_ff;
          end
        end
        OFS_DMSK:
          dmsk_ff <= pwdata[15:0];
        OFS_PROBE:
        begin
          // Direct stores refused while wide comparators own it
          if (!probe_locked)
          begin
            probe_val_ff <= pwdata[15:0];
            probe_msk_ff <= pwdata[31:16];
          end
        end
        OFS_STAT1:
        begin
          // Plain store, so address byte is overwritten too
          stat1_ff <= pwdata[14:0];
          stat1_msk_ff <= pwdata[30:16];
        end
        OFS_STAT2:
        begin
          stat2_ff <= pwdata[14:0];
          stat2_msk_ff <= pwdata[30:16];
        end
        OFS_COND:
        begin
          if (!bad_cond)
            cond_ff <= pwdata[5:0];
        end
        default:
        begin
          // Unmapped or read-only, nothing stored
        end
      endcase
    end
  end

  // ****************************************************************
  // Capture mapping
  // ****************************************************************
  logic [14:0] cap_status;
  logic [15:0] cap_probe;
  tcs_rec_t rec;

  // Status slice per mode
  always_comb
  begin
    cap_status[6:4] = bus.func_code;
    cap_status[3] = 1'b0;
    cap_status[2] = bus.user_system_cycle;
    cap_status[1] = bus.read_cycle;
    cap_status[0] = bus.single_octet_size;
    if (mode_ff == MODE_FULL_ADDR)
      // Interrupt, fault and autovector inputs are dropped here
      cap_status[14:7] = bus.addr[31:24];
    else
    begin
      cap_status[14] = bus.interrupt_pending;
      cap_status[13] = bus.autovector;
      cap_status[12] = break_action;
      cap_status[11:9] = bus.interrupt_level_lines;
      cap_status[8] = bus.bus_error_flag;
      cap_status[7] = bus.access_violation;
    end
  end

  // Probe slice: external probe only in base mode
  assign cap_probe = (mode_ff == MODE_BASE) ? bus.probe : bus.data[15:0];

  always_comb
  begin
    rec.addr = bus.addr[23:0];
    rec.data = bus.data[31:16];
    rec.status = cap_status;
    rec.probe = cap_probe;
    rec.extra = {bus.op_cycle_start, bus.sized_transfer_ack_high,
                 bus.sized_transfer_ack_low, bus.transfer_size_bit_high,
                 bus.transfer_size_bit_low};
  end

  // ****************************************************************
  // Comparators and break
  // ****************************************************************
  logic m_addr;
  logic m_data1;
  logic m_data2;
  logic m_stat1;
  logic m_stat2;
  logic m_probe;
  logic [5:0] hits;
  logic [5:0] eff_cond;
  logic cond_true;
  logic [5:0] hits_ff;          // Last cycle's matches, for software
  logic break_ff;

  assign m_addr = hit16(rec.addr[15:0], addr_val_ff[15:0], addr_msk_ff[15:0])
               && hit16({8'h00, rec.addr[23:16]}, {8'h00, addr_val_ff[23:16]},
                        {8'hff, addr_msk_ff[23:16]});
  assign m_probe = hit16(rec.probe, probe_val_ff, probe_msk_ff);
  // Wide data matches need the shared low word as well
  assign m_data1 = hit16(rec.data, data1_ff, dmsk_ff) && (!probe_locked || m_probe);
  assign m_data2 = hit16(rec.data, data2_ff, dmsk_ff) && (!probe_locked || m_probe);
  // Status compare encodes as traced; software keeps one per category
  assign m_stat1 = hit16({1'b0, rec.status}, {1'b0, stat1_ff}, {1'b1, stat1_msk_ff});
  assign m_stat2 = hit16({1'b0, rec.status}, {1'b0, stat2_ff}, {1'b1, stat2_msk_ff});
  assign hits = {m_probe, m_stat2, m_stat1, m_data2, m_data1, m_addr};

  // Address high byte pulled in automatically in wide full-address use
  assign eff_cond = cond_ff | (addr_in_stat && cond_ff[COND_ADDR] ? 6'h08 : 6'h00);
  assign cond_true = (cond_ff != 6'h00) && ((hits & eff_cond) == eff_cond);

  // Break asserted the cycle after the matching cycle is seen
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      break_ff <= 1'b0;
    else if (cyc && cond_true)
      break_ff <= 1'b1;
    else if (wr_en && paddr == OFS_STATUS && pwdata[COND_BREAK])
      break_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hits_ff <= '0;
    else if (cyc)
      hits_ff <= hits;
  end

  assign break_action = break_ff;

  // Refused writes set a sticky error, which wins over clearing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      err_ff <= 1'b0;
    else if (wr_en && ((paddr == OFS_PROBE && probe_locked)
                       || (paddr == OFS_COND && bad_cond)))
      err_ff <= 1'b1;
    else if (wr_en && paddr == OFS_STATUS && pwdata[0])
      err_ff <= 1'b0;
  end

  // ****************************************************************
  // Trace buffer
  // ****************************************************************
  logic fifo_ready;
  logic fifo_valid;
  tcs_rec_t fifo_out;
  logic [1:0] word_ff;          // Which word of the record is read next
  logic pop;
  logic overrun_ff;             // Cycle lost while buffer full

  // Reading the last word of a record frees it
  assign pop = rd_en && paddr == OFS_TRACE && fifo_valid && word_ff == 2'(TRACE_WORDS - 1);

  tcs_fifo #(
    .WIDTH(REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(cyc),
    .in_ready(fifo_ready),
    .in_data(rec),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      word_ff <= '0;
    else if (rd_en && paddr == OFS_TRACE && fifo_valid)
      word_ff <= word_ff + 2'd1;
  end

  // Back-pressure is visible as a sticky overrun bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      overrun_ff <= 1'b0;
    else if (cyc && !fifo_ready)
      overrun_ff <= 1'b1;
    else if (wr_en && paddr == OFS_STATUS && pwdata[1])
      overrun_ff <= 1'b0;
  end

  // ****************************************************************
  // APB read path; one access cycle, answered from flip-flops
  // ****************************************************************
  logic [31:0] nxt_rdata;
  logic nxt_err;

  always_comb
  begin
    nxt_err = 1'b0;
    unique case (paddr)
      OFS_CTRL: nxt_rdata = {29'h0, wide_ff, mode_ff};
      OFS_ADDR_VAL: nxt_rdata = {8'h00, addr_val_ff};
      OFS_ADDR_MSK: nxt_rdata = {8'h00, addr_msk_ff};
      OFS_DATA1: nxt_rdata = {data1_ff, probe_val_ff};
      OFS_DATA2: nxt_rdata = {data2_ff, probe_val_ff};
      OFS_DMSK: nxt_rdata = {16'h0000, dmsk_ff};
      OFS_PROBE: nxt_rdata = {probe_msk_ff, probe_val_ff};
      OFS_STAT1: nxt_rdata = {1'b0, stat1_msk_ff, 1'b0, stat1_ff};
      OFS_STAT2: nxt_rdata = {1'b0, stat2_msk_ff, 1'b0, stat2_ff};
      OFS_COND: nxt_rdata = {26'h0, cond_ff};
      OFS_STATUS: nxt_rdata = {19'h0, hits_ff, break_ff, fifo_valid,
                               3'h0, overrun_ff, err_ff} & 32'h0000_3fe3;
      OFS_TRACE:
      begin
        unique case (word_ff)
          2'd0: nxt_rdata = {8'h00, fifo_out.addr};
          2'd1: nxt_rdata = {fifo_out.probe, fifo_out.data};
          2'd2: nxt_rdata = {12'h000, fifo_out.extra, fifo_out.status};
          default: nxt_rdata = {31'h0, fifo_valid};
        endcase
      end
      default:
      begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b1;
      end
    endcase
  end

  // Ready in the first cycle of access phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      prdata <= nxt_rdata;
      pslverr <= psel && !penable && (nxt_err || (pwrite && paddr == OFS_PROBE
                 && probe_locked) || (pwrite && paddr == OFS_COND && bad_cond));
    end
  end

endmodule : tcs_trace_cmp
`default_nettype wire

/* bench/tcs_target_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Target bus model, one traced cycle per request
// ********
module tcs_target_model
  import tcs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic go,
  input wire tcs_bus_t cyc,
  // Target pins and progress
  output var tcs_bus_t target_bus,
  output logic busy
);
  logic [3:0] cnt_ff = 4'h0; // Phase inside the current cycle
  tcs_bus_t last_ff = '0; // Values of the current cycle
  // Step through setup, strobe, hold and release
  always @(posedge clk)
  begin
    if (go && cnt_ff == 4'h0)
    begin
      last_ff <= cyc;
      cnt_ff <= 4'h1;
    end
    else if (cnt_ff != 4'h0)
      cnt_ff <= (cnt_ff == 4'hb) ? 4'h0 : cnt_ff + 4'h1;
  end
  // Released address and data lines show the inverse, so a stale value never looks valid
  always_comb
  begin
    target_bus = last_ff;
    target_bus.strobe = (cnt_ff >= 4'h3 && cnt_ff <= 4'h6);
    if (cnt_ff == 4'h0 || cnt_ff > 4'h9)
    begin
      target_bus.addr = ~last_ff.addr;
      target_bus.data = ~last_ff.data;
    end
  end
  assign busy = go || cnt_ff != 4'h0;
endmodule : tcs_target_model
`default_nettype wire

/* bench/tcs_trace_cmp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker
// ********
module tcs_trace_cmp_chk
  import tcs_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Target pins and break
  input wire tcs_bus_t target_bus,
  input wire logic break_action
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire setup = psel && !penable; // Setup cycle of a transfer
  wire acc = psel && penable && pready; // Transfer completes here
  logic [1:0] mode_ff; // Shadow of the trace mode
  logic wide_ff; // Shadow of the wide comparator enable
  logic strobe_d_ff; // Strobe pin one cycle ago
  logic [3:0] since_ff; // Cycles since a strobe rise, saturating
  // Shadow control register, so refusals can be predicted
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_ff <= RST_MODE;
      wide_ff <= 1'b0;
    end
    else if (acc && pwrite && paddr == OFS_CTRL)
    begin
      mode_ff <= pwdata[1:0];
      wide_ff <= pwdata[CTRL_WIDE_BIT];
    end
  end
  // Age of the last traced cycle; saturates to avoid wrap false alarms
  always_ff @(posedge clk)
  begin
    strobe_d_ff <= target_bus.strobe;
    if (sys_rst)
      since_ff <= 4'hf;
    else if (target_bus.strobe && !strobe_d_ff)
      since_ff <= 4'h0;
    else if (since_ff != 4'hf)
      since_ff <= since_ff + 4'h1;
  end
  property p_rdy_setup; setup |=> pready; endproperty
  property p_rdy_one; pready |=> !pready; endproperty
  property p_rdy_acc; pready |-> psel && penable; endproperty
  property p_err_rdy; pslverr |-> pready; endproperty
  property p_unmapped;
    setup && paddr > OFS_TRACE |=> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_probe_ref;
    setup && pwrite && wide_ff && mode_ff != MODE_BASE && paddr == OFS_PROBE |=> pslverr;
  endproperty
  property p_cond_ref;
    setup && pwrite && wide_ff && mode_ff != MODE_BASE && paddr == OFS_COND
      && pwdata[COND_PROBE] |=> pslverr;
  endproperty
  property p_brk_cause; $rose(break_action) |-> since_ff <= 4'h8; endproperty
  property p_brk_hold;
    break_action && !(acc && pwrite && paddr == OFS_STATUS && pwdata[6]) |=> break_action;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  a_probe_ref: assert property (p_probe_ref) else $error("probe write accepted");
  a_cond_ref: assert property (p_cond_ref) else $error("probe condition accepted");
  a_brk_cause: assert property (p_brk_cause) else $error("break without cycle");
  a_brk_hold: assert property (p_brk_hold) else $error("break dropped");
  c_brk: cover property ($rose(break_action));
  c_err: cover property (pslverr);
  c_pop: cover property (acc && !pwrite && paddr == OFS_TRACE);
endmodule : tcs_trace_cmp_chk
bind tcs_trace_cmp tcs_trace_cmp_chk #(.FIFO_DEPTH(FIFO_DEPTH)) tcs_trace_cmp_chk_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .target_bus(target_bus), .break_action(break_action));
`default_nettype wire

/* bench/trace_capture_status_comparator_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, x, g); end end
// ********
// Testbench
// ********
module trace_capture_status_comparator_test
  import tcs_pkg::*;
();
  logic clk = 1'b0, sys_rst = 1'b1; // Clock, reset high two cycles
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0, prdata, q; // Write, read and taken data
  logic pready, pslverr, break_action, busy, e, go = 1'b0; // Answers
  tcs_bus_t target_bus, cyc = '0; // Pins and requested cycle
  int miscompares = 0, total_checks = 0, cyc_cnt = 0;
  always #5 clk = ~clk;
  tcs_trace_cmp #(.FIFO_DEPTH(32)) tcs_trace_cmp_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .target_bus(target_bus), .break_action(break_action));
  tcs_target_model tcs_target_model_i (.clk(clk), .go(go), .cyc(cyc),
    .target_bus(target_bus), .busy(busy));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // One APB transfer; holds everything until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    apb(1'b1, a, d);
    `CHK("pslverr", x, e)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", x, q & m)
  endtask : rd
  // Hand one cycle to the target model and wait until it has passed
  task automatic drive(input tcs_bus_t v);
    cyc <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy)
      @(posedge clk);
  endtask : drive
  // Fixed status and handshake pattern beside the given address and data
  function automatic tcs_bus_t mk(input logic [31:0] a, input logic [31:0] d);
    mk = {a, d, 16'h3c5a, 18'b1_0_101_1_0_110_1_1_0_1_0_1_1_0, 1'b0};
  endfunction : mk
  // Pop one record and compare its four words
  task automatic chk_rec(input logic [1:0] md, input tcs_bus_t v);
    logic [14:0] st;
    logic [15:0] pr;
    st = {v[18:17], 1'b0, v[16:12], v[11:9], 1'b0, v[8:6]};
    if (md == MODE_FULL_ADDR)
      st[14:7] = v.addr[31:24];
    pr = (md == MODE_BASE) ? v.probe : v.data[15:0];
    rd(OFS_TRACE, '1, {8'h00, v.addr[23:0]});
    rd(OFS_TRACE, '1, {pr, v.data[31:16]});
    rd(OFS_TRACE, '1, {12'h000, v[5:1], st});
    rd(OFS_TRACE, 32'h1, 32'h1);
  endtask : chk_rec
  task automatic t_reset();
    rd(OFS_CTRL, 32'h7, {30'h0, RST_MODE});
    rd(OFS_COND, 32'h7f, 32'h0);
    rd(OFS_DMSK, 32'hffff, 32'hffff);
    wr(8'h30, 32'h0, 1'b1);
    rd(8'h34, '1, 32'h0);
    `CHK("pslverr", 1'b1, e)
    $display("test reset done");
  endtask : t_reset
  task automatic t_capture();
    tcs_bus_t v;
    for (int m = 0; m < 3; m++)
    begin
      v = mk(32'ha5c3_1e70 + m, 32'h1234_5678 ^ m);
      wr(OFS_CTRL, 32'(m), 1'b0);
      drive(v);
      chk_rec(2'(m), v);
    end
    $display("test capture done");
  endtask : t_capture
  // Fill the trace buffer past full, then drain it to empty
  task automatic t_fifo();
    wr(OFS_CTRL, 32'h0, 1'b0);
    for (int i = 0; i < 33; i++)
      drive(mk(32'h100 + i, 32'h0));
    rd(OFS_STATUS, 32'h22, 32'h22);
    for (int i = 0; i < 32; i++)
    begin
      rd(OFS_TRACE, '1, 32'h100 + i);
      repeat (3) apb(1'b0, OFS_TRACE, 32'h0);
    end
    rd(OFS_STATUS, 32'h20, 32'h0);
    wr(OFS_STATUS, 32'h2, 1'b0);
    rd(OFS_STATUS, 32'h2, 32'h0);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_status();
    wr(OFS_CTRL, 32'h1, 1'b0);
    wr(OFS_STAT2, 32'h1088_4b66, 1'b0);
    wr(OFS_COND, 32'h10, 1'b0);
    drive(mk(32'h0, 32'h0));
    `CHK("break_action", 1'b1, break_action)
    wr(OFS_STATUS, 32'h40, 1'b0);
    wr(OFS_STAT2, 32'h1088_4b67, 1'b0);
    drive(mk(32'h0, 32'h0));
    `CHK("break_action", 1'b0, break_action)
    rd(OFS_STATUS, 32'h1f80, 32'h1780);
    $display("test status done");
  endtask : t_status
  task automatic t_data();
    wr(OFS_CTRL, 32'h5, 1'b0);
    wr(OFS_DMSK, 32'h0, 1'b0);
    wr(OFS_DATA1, 32'h1234_5678, 1'b0);
    rd(OFS_PROBE, '1, 32'h0000_5678);
    wr(OFS_DATA2, 32'h9abc_4321, 1'b0);
    rd(OFS_PROBE, 32'hffff, 32'h4321);
    wr(OFS_COND, 32'h2, 1'b0);
    drive(mk(32'h0, 32'h1234_5678));
    `CHK("break_action", 1'b0, break_action)
    drive(mk(32'h0, 32'h1235_4321));
    `CHK("break_action", 1'b0, break_action)
    drive(mk(32'h0, 32'h1234_4321));
    `CHK("break_action", 1'b1, break_action)
    wr(OFS_STATUS, 32'h40, 1'b0);
    `CHK("break_action", 1'b0, break_action)
    wr(OFS_PROBE, 32'h0, 1'b1);
    wr(OFS_COND, 32'h22, 1'b1);
    rd(OFS_PROBE, 32'hffff, 32'h4321);
    rd(OFS_COND, 32'h3f, 32'h2);
    rd(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_STATUS, 32'h1, 1'b0);
    rd(OFS_STATUS, 32'h1, 32'h0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    wr(OFS_PROBE, 32'hffff_0000, 1'b0);
    $display("test data done");
  endtask : t_data
  task automatic t_addr();
    wr(OFS_CTRL, 32'h6, 1'b0);
    wr(OFS_ADDR_MSK, 32'h0, 1'b0);
    wr(OFS_ADDR_VAL, 32'hab12_3456, 1'b0);
    rd(OFS_STAT1, 32'h7f80_7f80, 32'h0000_5580);
    wr(OFS_COND, 32'h1, 1'b0);
    drive(mk(32'hac12_3456, 32'h0));
    `CHK("break_action", 1'b0, break_action)
    drive(mk(32'hab12_3456, 32'h0));
    `CHK("break_action", 1'b1, break_action)
    wr(OFS_STAT1, 32'h7fff_0000, 1'b0);
    rd(OFS_STAT1, 32'h7f80, 32'h0);
    $display("test address done");
  endtask : t_addr
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_capture();
    t_fifo();
    t_status();
    t_data();
    t_addr();
    end_sim();
  end
  // Cut a hang short; the run needs only about a thousand cycles
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
endmodule : trace_capture_status_comparator_test
`default_nettype wire
